// [line_watcher.sv]
/* External equipment on the watchdog line: counts rising edges.
 Assumes the line is sampled on the system clock. */
`timescale 1ns/10ps
module line_watcher
(
	input wire logic clk_in,
	input wire logic line_in,
	output int rises_out = 0
);
	logic last = 1'b0;
	always_ff @(posedge clk_in)
	begin
		last <= line_in;
		if (line_in && !last)
			rises_out <= rises_out + 1;
	end
endmodule : line_watcher

// [testbench.sv]
/* Self-checking bench for the watchdog fault unit.
 Assumes 1 ms ticks of 20000 cycles and a one-wait read. */
`timescale 1ns/10ps
module testbench;
	import wdog_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	avmm_req_t req = '0;
	avmm_rsp_t rsp;
	logic oh = 1'b0;
	logic sb = 1'b0;
	ttl_pins_t ttl;
	logic [7:0] iso;
	logic line, halt, red, irq;
	int err_count = 0;
	int num_checks = 0;
	int rises;
	logic [31:0] rd;
	always #25 clk = ~clk;
	wdog_fault_unit dut_u (.CLK_IN(clk), .RST_IN(rst), .AVM_REQ_IN(req), .AVM_RSP_OUT(rsp),
		.OVERHEAT_IN(oh), .SAFE_BOOT_IN(sb), .TTL_NORMAL_IN(8'h5a), .ISO_NORMAL_IN(8'h3c),
		.TTL_PINS_OUT(ttl), .ISO_OUT(iso), .WDOG_LINE_OUT(line), .HALT_OUT(halt),
		.POWER_RED_OUT(red), .IRQ_OUT(irq));
	line_watcher watch_p (.clk_in(clk), .line_in(line), .rises_out(rises));
	task automatic end_sim;
		if (err_count == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : end_sim
	task automatic chk(input logic [31:0] seen, input logic [31:0] want);
		num_checks++;
		if (seen !== want)
		begin
			err_count++;
			$display("BAD %0t seen %h want %h", $time, seen, want);
		end
	endtask : chk
	// request stands until waitrequest is seen low at a rising edge; the
	// values read right after the edge are still the pre-edge ones
	task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
		req <= '{a, ~w, w, d};
		@(posedge clk);
		while (rsp.waitrequest)
			@(posedge clk);
		rd = rsp.readdata;
		req <= '0;
		@(posedge clk);
	endtask : bus
	task automatic do_reset;
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
	endtask : do_reset
	initial
	begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		bus(0, ADDR_INTERVAL, 0);
		chk(rd, 32'h3e8);
		bus(1, ADDR_INTERVAL, 32'hffff);
		bus(0, ADDR_INTERVAL, 0);
		chk(rd, 32'hfffe);
		bus(0, 5'h1e, 0);
		chk(rd, UNMAPPED_READ);
		bus(1, ADDR_INTERVAL, 2);
		bus(1, ADDR_IRQ_MASK, 1);
		bus(1, ADDR_CTRL, 32'h3);
		repeat (30000) @(posedge clk);
		bus(1, ADDR_SERVICE, 0);
		repeat (20000) @(posedge clk);
		chk(line, 0);
		bus(0, ADDR_STATUS, 0);
		chk(rd[0], 0);
		repeat (10100) @(posedge clk);
		chk(line, 1);
		chk(irq, 1);
		bus(1, ADDR_SERVICE, 0);
		chk(line, 1);
		bus(1, ADDR_CTRL, 32'h1);
		bus(1, ADDR_SERVICE, 0);
		bus(0, ADDR_STATUS, 0);
		chk(rd[0], 1);
		bus(1, ADDR_IRQ_STAT, 1);
		chk(irq, 0);
		bus(1, ADDR_CTRL, 0);
		bus(0, ADDR_STATUS, 0);
		chk(rd[0], 0);
		chk(line, 0);
		chk(rises, 1);
		bus(1, ADDR_INTERVAL, 1);
		bus(1, ADDR_SD_TTL, 32'h4924);
		bus(1, ADDR_SD_ISO, 32'ha5);
		bus(1, ADDR_CTRL, 32'hd);
		repeat (20100) @(posedge clk);
		chk(halt, 1);
		chk(red, 1);
		chk(iso, 8'ha5);
		chk(ttl.oe_n, 8'h24);
		chk(ttl.out & ~ttl.oe_n, 8'h92);
		bus(1, ADDR_CTRL, 0);
		chk(halt, 1);
		do_reset();
		chk(halt, 0);
		sb <= 1'b1;
		bus(1, ADDR_CTRL, 32'h8);
		bus(1, ADDR_SD_ISO, 32'ha5);
		oh <= 1'b1;
		repeat (10) @(posedge clk);
		chk(red, 1);
		chk(iso, 8'h3c);
		oh <= 1'b0;
		repeat (10) @(posedge clk);
		chk(halt, 1);
		sb <= 1'b0;
		do_reset();
		bus(1, ADDR_CTRL, 32'h8);
		bus(1, ADDR_SD_ISO, 32'ha5);
		oh <= 1'b1;
		repeat (10) @(posedge clk);
		chk(iso, 8'ha5);
		end_sim();
	end
	initial
	begin
		repeat (95000) @(posedge clk);
		err_count++;
		end_sim();
	end
endmodule : testbench

// [wdog_fault_unit.sv]
/*
 Software watchdog and fault unit: millisecond countdown armed and
 serviced by software, three expiry actions, overheat halt, shutdown
 states for TTL and isolated outputs, Avalon-MM register slave and a
 masked level interrupt.
 Assumes pins (overheat, safe-boot switch) are asynchronous and are
 synchronised here; the system reset is the only way out of a halt.
*/
//
// Behaviour
// - countdown interval programmable in 1 ms steps, at most 65534 ms
// - software picks one expiry action: indicate, drive line, or shutdown
// - indicate action: expiry flag reads true when expired, false otherwise
// - indicate action: expiry flag stays set until software disarms
// - disarming returns watchdog I/O and the expiry flag to inactive, unless an expiry lands in the same cycle
// - line action: output line high when expired, low when not
// - line action: line stays high after expiry until disarm or a change of action, despite service
// - shutdown action: expiry halts processing and turns power-good red
// - shutdown action with shutdown mode: outputs forced to configured states
// - overheat halts, turns indicator red, forces outputs if shutdown mode
// - TTL shutdown state high, low or hi-Z; isolated state on or off
// - safe-boot switch on overrides shutdown mode; outputs never forced
// - any halt holds until system reset; clearing cause does not resume
`timescale 1ns/10ps
module wdog_fault_unit
(
	input wire logic CLK_IN,
	input wire logic RST_IN,
	input wdog_pkg::avmm_req_t AVM_REQ_IN,
	output wdog_pkg::avmm_rsp_t AVM_RSP_OUT,
	input wire logic OVERHEAT_IN,
	input wire logic SAFE_BOOT_IN,
	input wire logic [wdog_pkg::N_TTL-1:0] TTL_NORMAL_IN,
	input wire logic [wdog_pkg::N_ISO-1:0] ISO_NORMAL_IN,
	output wdog_pkg::ttl_pins_t TTL_PINS_OUT,
	output logic [wdog_pkg::N_ISO-1:0] ISO_OUT,
	output logic WDOG_LINE_OUT,
	output logic HALT_OUT,
	output logic POWER_RED_OUT,
	output logic IRQ_OUT
);
	import wdog_pkg::*;

	logic [1:0] overheat_sync;
	logic [1:0] safe_sync;
	logic armed;
	wd_action_t action;
	logic shutdown_en;
	logic [15:0] interval;
	logic [15:0] count;
	logic expired;
	logic halted;
	logic [1:0] irq_stat;
	logic [1:0] irq_mask;
	logic [2*N_TTL-1:0] sd_ttl;
	logic [N_ISO-1:0] sd_iso;
	logic tick;
	logic rd_pending;
	logic [31:0] next_readdata;
	logic [31:0] readdata;
	logic overheat_rise;
	logic overheat_prev;
	logic expire_event;
	logic forced;
	logic wr_ctrl;
	logic wr_interval;
	logic wr_service;
	logic wr_irq_stat;
	logic [15:0] wr_interval_val;
	logic [1:0] wr_action;
	logic wr_disarm;
	logic wr_irq_mask;
	logic wr_sd_ttl;
	logic wr_sd_iso;

	// one-cycle read wait: readdata registered, answer on the second edge
	assign AVM_RSP_OUT.waitrequest = AVM_REQ_IN.read && !rd_pending;
	assign AVM_RSP_OUT.readdata = readdata;

	assign wr_ctrl = AVM_REQ_IN.write && AVM_REQ_IN.address == ADDR_CTRL;
	assign wr_interval = AVM_REQ_IN.write && AVM_REQ_IN.address == ADDR_INTERVAL;
	assign wr_service = AVM_REQ_IN.write && AVM_REQ_IN.address == ADDR_SERVICE;
	assign wr_irq_stat = AVM_REQ_IN.write && AVM_REQ_IN.address == ADDR_IRQ_STAT;
	assign wr_irq_mask = AVM_REQ_IN.write && AVM_REQ_IN.address == ADDR_IRQ_MASK;
	assign wr_sd_ttl = AVM_REQ_IN.write && AVM_REQ_IN.address == ADDR_SD_TTL;
	assign wr_sd_iso = AVM_REQ_IN.write && AVM_REQ_IN.address == ADDR_SD_ISO;
	assign wr_disarm = wr_ctrl && !AVM_REQ_IN.writedata[CTRL_ARM];
	assign wr_action = AVM_REQ_IN.writedata[CTRL_ACT_LO+1:CTRL_ACT_LO];

	// clamp to the largest legal interval, zero becomes one tick
	always_comb
	begin
		wr_interval_val = AVM_REQ_IN.writedata[15:0];
		if (wr_interval_val > INTERVAL_MAX)
			wr_interval_val = INTERVAL_MAX;
		else if (wr_interval_val == 16'h0000)
			wr_interval_val = 16'h0001;
	end

	always_ff @(posedge CLK_IN or posedge RST_IN)
	begin
		if (RST_IN)
		begin
			overheat_sync <= 2'h0;
			safe_sync <= 2'h0;
		end
		else
		begin
			overheat_sync <= {overheat_sync[0], OVERHEAT_IN};
			safe_sync <= {safe_sync[0], SAFE_BOOT_IN};
		end
	end

	wdog_tick u_tick
	(
		.CLK_IN(CLK_IN),
		.RST_IN(RST_IN),
		.RUN_IN(armed && !expired && !halted),
		.TICK_OUT(tick)
	);

	// control word: arm, expiry action and shutdown enable
	always_ff @(posedge CLK_IN or posedge RST_IN)
	begin
		if (RST_IN)
		begin
			armed <= 1'b0;
			action <= ACT_INDICATE;
			shutdown_en <= 1'b0;
		end
		else if (wr_ctrl)
		begin
			armed <= AVM_REQ_IN.writedata[CTRL_ARM];
			// one action only; the unused code falls back to indicate
			if (wr_action == 2'(ACT_LINE))
				action <= ACT_LINE;
			else if (wr_action == 2'(ACT_SHUTDOWN))
				action <= ACT_SHUTDOWN;
			else
				action <= ACT_INDICATE;
			shutdown_en <= AVM_REQ_IN.writedata[CTRL_SDEN];
		end
	end

	// a new interval is used from the next reload, not mid-count
	always_ff @(posedge CLK_IN or posedge RST_IN)
	begin
		if (RST_IN)
			interval <= INTERVAL_RESET;
		else if (wr_interval)
			interval <= wr_interval_val;
	end

	always_ff @(posedge CLK_IN or posedge RST_IN)
	begin
		if (RST_IN)
			irq_mask <= IRQ_RESET;
		else if (wr_irq_mask)
			irq_mask <= AVM_REQ_IN.writedata[1:0];
	end

	// shutdown states stay writable while halted, so forcing can be reshaped
	always_ff @(posedge CLK_IN or posedge RST_IN)
	begin
		if (RST_IN)
		begin
			sd_ttl <= '0;
			sd_iso <= '0;
		end
		else
		begin
			if (wr_sd_ttl)
				sd_ttl <= AVM_REQ_IN.writedata[2*N_TTL-1:0];
			if (wr_sd_iso)
				sd_iso <= AVM_REQ_IN.writedata[N_ISO-1:0];
		end
	end

	// countdown
	always_ff @(posedge CLK_IN or posedge RST_IN)
	begin
		if (RST_IN)
			count <= INTERVAL_RESET;
		else if (!armed || wr_disarm)
			count <= interval;
		else if (wr_service && !expired)
			count <= interval;
		else if (tick && count != 16'h0000)
			count <= count - 16'h0001;
	end

	assign expire_event = armed && !expired && tick && count == 16'h0001;

	// expiry flag: sticky until disarm, service cannot clear it
	// an expiry landing with the disarm wins, so it is never lost
	always_ff @(posedge CLK_IN or posedge RST_IN)
	begin
		if (RST_IN)
			expired <= 1'b0;
		else if (expire_event)
			expired <= 1'b1;
		else if (wr_disarm)
			expired <= 1'b0;
	end

	// overheat edge only feeds the interrupt; the halt is level-caught
	always_ff @(posedge CLK_IN or posedge RST_IN)
	begin
		if (RST_IN)
			overheat_prev <= 1'b0;
		else
			overheat_prev <= overheat_sync[1];
	end

	assign overheat_rise = overheat_sync[1] && !overheat_prev;

	// halt latch: only the system reset releases it
	always_ff @(posedge CLK_IN or posedge RST_IN)
	begin
		if (RST_IN)
			halted <= 1'b0;
		else if (overheat_sync[1])
			halted <= 1'b1;
		else if (expire_event && action == ACT_SHUTDOWN)
			halted <= 1'b1;
	end

	// safe-boot switch overrides the software shutdown enable
	assign forced = halted && shutdown_en && !safe_sync[1];

	always_ff @(posedge CLK_IN or posedge RST_IN)
	begin
		if (RST_IN)
		begin
			HALT_OUT <= 1'b0;
			POWER_RED_OUT <= 1'b0;
			WDOG_LINE_OUT <= 1'b0;
		end
		else
		begin
			HALT_OUT <= halted;
			POWER_RED_OUT <= halted;
			WDOG_LINE_OUT <= armed && expired && action == ACT_LINE;
		end
	end

	// per-output drive: normal value, or shutdown state while forced
	genvar i;
	generate
		for (i = 0; i < N_TTL; i++)
		begin : g_ttl
			always_ff @(posedge CLK_IN or posedge RST_IN)
			begin
				if (RST_IN)
				begin
					TTL_PINS_OUT.out[i] <= 1'b0;
					TTL_PINS_OUT.oe_n[i] <= 1'b0;
				end
				else if (forced)
				begin
					TTL_PINS_OUT.out[i] <= sd_ttl[2*i+1:2*i] == 2'(SD_HIGH);
					TTL_PINS_OUT.oe_n[i] <= sd_ttl[2*i+1:2*i] == 2'(SD_HIZ);
				end
				else
				begin
					TTL_PINS_OUT.out[i] <= TTL_NORMAL_IN[i];
					TTL_PINS_OUT.oe_n[i] <= 1'b0;
				end
			end
		end
		for (i = 0; i < N_ISO; i++)
		begin : g_iso
			always_ff @(posedge CLK_IN or posedge RST_IN)
			begin
				if (RST_IN)
					ISO_OUT[i] <= 1'b0;
				else if (forced)
					ISO_OUT[i] <= sd_iso[i];
				else
					ISO_OUT[i] <= ISO_NORMAL_IN[i];
			end
		end
	endgenerate

	// sticky interrupt status, write one to clear; a new event wins
	always_ff @(posedge CLK_IN or posedge RST_IN)
	begin
		if (RST_IN)
			irq_stat <= IRQ_RESET;
		else
		begin
			irq_stat[IRQ_EXPIRE] <= expire_event ||
				(irq_stat[IRQ_EXPIRE] && !(wr_irq_stat && AVM_REQ_IN.writedata[IRQ_EXPIRE]));
			irq_stat[IRQ_OVERHEAT] <= overheat_rise ||
				(irq_stat[IRQ_OVERHEAT] && !(wr_irq_stat && AVM_REQ_IN.writedata[IRQ_OVERHEAT]));
		end
	end

	assign IRQ_OUT = |(irq_stat & irq_mask);

	always_comb
	begin
		next_readdata = UNMAPPED_READ;
		unique case (AVM_REQ_IN.address)
			ADDR_CTRL:
			begin
				next_readdata[CTRL_ARM] = armed;
				next_readdata[CTRL_ACT_LO+1:CTRL_ACT_LO] = action;
				next_readdata[CTRL_SDEN] = shutdown_en;
			end
			ADDR_INTERVAL:
				next_readdata[15:0] = interval;
			ADDR_STATUS:
			begin
				next_readdata[ST_EXPIRED] = expired;
				next_readdata[ST_HALTED] = halted;
				next_readdata[ST_FAULT_RED] = halted;
				next_readdata[ST_FORCED] = forced;
				next_readdata[ST_SAFE_BOOT] = safe_sync[1];
				next_readdata[ST_COUNT_LO+15:ST_COUNT_LO] = count;
			end
			ADDR_IRQ_STAT:
				next_readdata[1:0] = irq_stat;
			ADDR_IRQ_MASK:
				next_readdata[1:0] = irq_mask;
			ADDR_SD_TTL:
				next_readdata[2*N_TTL-1:0] = sd_ttl;
			ADDR_SD_ISO:
				next_readdata[N_ISO-1:0] = sd_iso;
			default:
				next_readdata = UNMAPPED_READ;
		endcase
	end

	always_ff @(posedge CLK_IN or posedge RST_IN)
	begin
		if (RST_IN)
		begin
			rd_pending <= 1'b0;
			readdata <= 32'h00000000;
		end
		else
		begin
			rd_pending <= AVM_REQ_IN.read && !rd_pending;
			if (AVM_REQ_IN.read && !rd_pending)
				readdata <= next_readdata;
		end
	end

endmodule : wdog_fault_unit

// [wdog_fault_unit_assertions.sv]
/* Checker for the watchdog fault unit, bound to its ports.
 Assumes the design package and one clock domain. */
`timescale 1ns/10ps
module wdog_checker
(
	input wire logic CLK_IN,
	input wire logic RST_IN,
	input wdog_pkg::avmm_req_t AVM_REQ_IN,
	input wdog_pkg::avmm_rsp_t AVM_RSP_OUT,
	input wire logic OVERHEAT_IN,
	input wire logic [wdog_pkg::N_TTL-1:0] TTL_NORMAL_IN,
	input wire logic [wdog_pkg::N_ISO-1:0] ISO_NORMAL_IN,
	input wdog_pkg::ttl_pins_t TTL_PINS_OUT,
	input wire logic [wdog_pkg::N_ISO-1:0] ISO_OUT,
	input wire logic WDOG_LINE_OUT,
	input wire logic HALT_OUT,
	input wire logic POWER_RED_OUT
);
	import wdog_pkg::*;
	logic wr_d1;
	logic wr_d2;
	// line may only drop one or two edges after a control write lands
	always_ff @(posedge CLK_IN or posedge RST_IN)
	begin
		if (RST_IN)
		begin
			wr_d1 <= 1'b0;
			wr_d2 <= 1'b0;
		end
		else
		begin
			wr_d1 <= AVM_REQ_IN.write && AVM_REQ_IN.address == ADDR_CTRL;
			wr_d2 <= wr_d1;
		end
	end
	default clocking @(posedge CLK_IN); endclocking
	default disable iff (RST_IN);
	read_wait_a: assert property (AVM_REQ_IN.read && !$past(AVM_REQ_IN.read)
		|-> AVM_RSP_OUT.waitrequest ##1 !AVM_RSP_OUT.waitrequest)
		else $error("read wait not one cycle");
	write_nowait_a: assert property (AVM_REQ_IN.write |-> !AVM_RSP_OUT.waitrequest)
		else $error("write waited");
	halt_hold_a: assert property (HALT_OUT |=> HALT_OUT)
		else $error("halt released");
	red_halt_a: assert property (HALT_OUT |-> POWER_RED_OUT)
		else $error("halt without red");
	overheat_halt_a: assert property (OVERHEAT_IN |-> ##[1:6] HALT_OUT)
		else $error("overheat did not halt");
	iso_normal_a: assert property (!HALT_OUT && !$past(RST_IN)
		|-> ISO_OUT == $past(ISO_NORMAL_IN))
		else $error("iso not normal");
	ttl_normal_a: assert property (!HALT_OUT && !$past(RST_IN)
		|-> TTL_PINS_OUT.out == $past(TTL_NORMAL_IN) && TTL_PINS_OUT.oe_n == 8'h00)
		else $error("ttl not normal");
	line_hold_a: assert property ($fell(WDOG_LINE_OUT) |-> wr_d1 || wr_d2)
		else $error("line dropped");
	cover property ($rose(WDOG_LINE_OUT));
	cover property ($rose(HALT_OUT));
	cover property (AVM_REQ_IN.read && !AVM_RSP_OUT.waitrequest);
endmodule : wdog_checker
bind wdog_fault_unit wdog_checker watch_u (.CLK_IN(CLK_IN), .RST_IN(RST_IN),
	.AVM_REQ_IN(AVM_REQ_IN), .AVM_RSP_OUT(AVM_RSP_OUT), .OVERHEAT_IN(OVERHEAT_IN),
	.TTL_NORMAL_IN(TTL_NORMAL_IN), .ISO_NORMAL_IN(ISO_NORMAL_IN),
	.TTL_PINS_OUT(TTL_PINS_OUT), .ISO_OUT(ISO_OUT), .WDOG_LINE_OUT(WDOG_LINE_OUT),
	.HALT_OUT(HALT_OUT), .POWER_RED_OUT(POWER_RED_OUT));

// [wdog_pkg.sv]
/*
 Package for the software watchdog and fault unit: register map, field
 positions, reset values, action codes and timing constants.
 Assumes a 20 MHz system clock and a 32-bit Avalon-MM register bus.
*/
package wdog_pkg;

	localparam int CLK_HZ = 20000000;
	localparam int TICK_MS = 1;
	localparam int TICK_CYCLES = (CLK_HZ / 1000) * TICK_MS;

	localparam logic [15:0] INTERVAL_MAX = 16'hfffe;
	localparam logic [15:0] INTERVAL_RESET = 16'h03e8;

	localparam int N_TTL = 8;
	localparam int N_ISO = 8;

	// word-aligned byte addresses
	localparam logic [4:0] ADDR_CTRL = 5'h00;
	localparam logic [4:0] ADDR_INTERVAL = 5'h04;
	localparam logic [4:0] ADDR_SERVICE = 5'h08;
	localparam logic [4:0] ADDR_STATUS = 5'h0c;
	localparam logic [4:0] ADDR_IRQ_STAT = 5'h10;
	localparam logic [4:0] ADDR_IRQ_MASK = 5'h14;
	localparam logic [4:0] ADDR_SD_TTL = 5'h18;
	localparam logic [4:0] ADDR_SD_ISO = 5'h1c;

	// control fields
	localparam int CTRL_ARM = 0;
	localparam int CTRL_ACT_LO = 1;
	localparam int CTRL_SDEN = 3;

	// status fields
	localparam int ST_EXPIRED = 0;
	localparam int ST_HALTED = 1;
	localparam int ST_FAULT_RED = 2;
	localparam int ST_FORCED = 3;
	localparam int ST_SAFE_BOOT = 4;
	localparam int ST_COUNT_LO = 16;

	// interrupt fields
	localparam int IRQ_EXPIRE = 0;
	localparam int IRQ_OVERHEAT = 1;
	localparam logic [1:0] IRQ_RESET = 2'h0;

	localparam logic [31:0] UNMAPPED_READ = 32'h00000000;

	typedef enum logic [1:0] {
		ACT_INDICATE = 2'h0,
		ACT_LINE = 2'h1,
		ACT_SHUTDOWN = 2'h2
	} wd_action_t;

	// per-TTL shutdown state: two bits per output
	typedef enum logic [1:0] {
		SD_LOW = 2'h0,
		SD_HIGH = 2'h1,
		SD_HIZ = 2'h2
	} sd_ttl_t;

	typedef struct packed {
		logic [4:0] address;
		logic read;
		logic write;
		logic [31:0] writedata;
	} avmm_req_t;

	typedef struct packed {
		logic [31:0] readdata;
		logic waitrequest;
	} avmm_rsp_t;

	typedef struct packed {
		logic [N_TTL-1:0] out;
		logic [N_TTL-1:0] oe_n;
	} ttl_pins_t;

endpackage : wdog_pkg

// [wdog_tick.sv]
/*
 Millisecond tick generator for the watchdog countdown.
 Assumes the package clock rate; runs only while enabled so each armed
 period starts from a full millisecond.
*/
`timescale 1ns/10ps
module wdog_tick
(
	input wire logic CLK_IN,
	input wire logic RST_IN,
	input wire logic RUN_IN,
	output logic TICK_OUT
);
	import wdog_pkg::*;

	localparam logic [14:0] TICK_LAST = 15'(TICK_CYCLES - 1);

	logic [14:0] count;

	always_ff @(posedge CLK_IN or posedge RST_IN)
	begin
		if (RST_IN)
		begin
			count <= 15'h0000;
			TICK_OUT <= 1'b0;
		end
		else if (!RUN_IN)
		begin
			count <= 15'h0000;
			TICK_OUT <= 1'b0;
		end
		else if (count == TICK_LAST)
		begin
			count <= 15'h0000;
			TICK_OUT <= 1'b1;
		end
		else
		begin
			count <= count + 15'h0001;
			TICK_OUT <= 1'b0;
		end
	end

endmodule : wdog_tick
